// ---- aso_host_model.sv ----
`timescale 1ns/1ns
module aso_host_model
    import aso_pkg::*;
#(
    // encoder levels for short and long cables, plain defaults
    parameter logic [1:0] LEVEL_SHORT = 2'h1,
    parameter logic [1:0] LEVEL_LONG = 2'h2
) (
    // clock
    input wire logic clk,
    // requested pin levels, pacing and cable choice
    input wire aso_pins_type pinsCmd,
    input wire logic slow,
    input wire logic cableLong,
    // pins toward the device and chosen encoder level
    output aso_pins_type pins,
    output logic [1:0] encLevel
);
    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    aso_pins_type stage;

    // slow mode adds one stage so the device sees late, ragged inputs
    always @(posedge clk) begin
        stage <= pinsCmd;
        pins <= slow ? stage : pinsCmd;
    end

    // ----------------------------------------------------------------
    // operator setting
    // ----------------------------------------------------------------
    // longer cables lose more voltage, so they need the higher level
    assign encLevel = cableLong ? LEVEL_LONG : LEVEL_SHORT;
endmodule

// ---- aso_pkg.sv ----
package aso_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ASO_ADDR_CTRL = 8'h00;
    localparam logic [7:0] ASO_ADDR_THRESH = 8'h04;
    localparam logic [7:0] ASO_ADDR_STATUS = 8'h08;
    localparam logic [7:0] ASO_ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ASO_ADDR_IRQ_MASK = 8'h10;

    // ----------------------------------------------------------------
    // control field positions and reset values
    // ----------------------------------------------------------------
    localparam int ASO_CTRL_VARIANT = 0;
    localparam int ASO_CTRL_POINTS_LSB = 1;
    localparam int ASO_CTRL_ASSIGN_LSB = 4;
    localparam int ASO_CTRL_DRIVE = 8;
    localparam int ASO_CTRL_ENCV_LSB = 12;
    localparam logic [1:0] ASO_POINTS_FOUR = 2'h1;
    localparam logic [1:0] ASO_POINTS_EIGHT = 2'h2;
    localparam logic [3:0] ASO_ASSIGN_ALL = 4'hF;
    localparam logic [15:0] ASO_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ASO_THRESH_RESET = 16'hFFFF;

    // ----------------------------------------------------------------
    // load current steps, in quarter percent (6.25 % and 18.75 %)
    // ----------------------------------------------------------------
    localparam logic [15:0] ASO_STEP_FINE = 16'h0019;
    localparam logic [15:0] ASO_STEP_COARSE = 16'h004B;

    // ----------------------------------------------------------------
    // interrupt bits
    // ----------------------------------------------------------------
    localparam int ASO_IRQ_W = 6;
    localparam int ASO_IRQ_MISS = 0;
    localparam int ASO_IRQ_MOTION_END_FLAG = 1;
    localparam int ASO_IRQ_CRIT = 2;
    localparam int ASO_IRQ_MINOR = 3;
    localparam int ASO_IRQ_OVL = 4;
    localparam int ASO_IRQ_READY = 5;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic opStart;
        logic pressEnd;
        logic pressContact;
        logic pressActive;
        logic homeActive;
        logic posDone;
        logic critAlarm;
        logic lightAlarm;
        logic readyIn;
    } aso_pins_type;

    localparam int ASO_PINS_W = $bits(aso_pins_type);

    typedef struct packed {
        logic miss_press_flag;
        logic controller_ready_flag;
        logic [3:0] currentRate;
        logic pressing;
        logic homing_in_progress;
        logic critical_fault_n;
        logic motion_end_flag;
        logic overload_warning_n;
        logic minor_fault_n;
        logic alarm_flag_n;
        logic drivePulseMode;
        logic [1:0] encVoltLevel;
    } aso_flags_type;

    localparam aso_flags_type ASO_FLAGS_RESET = '{
        miss_press_flag: 1'b0, controller_ready_flag: 1'b0, currentRate: 4'h0,
        pressing: 1'b0, homing_in_progress: 1'b0, critical_fault_n: 1'b1,
        motion_end_flag: 1'b0, overload_warning_n: 1'b1, minor_fault_n: 1'b1,
        alarm_flag_n: 1'b1, drivePulseMode: 1'b0, encVoltLevel: 2'h0};

endpackage

// ---- aso_rate_quant.sv ----
`timescale 1ns/1ns
module aso_rate_quant
    import aso_pkg::*;
(
    // load current in quarter percent of rated
    input wire logic [15:0] load,
    // step select: high for the fine step
    input wire logic fineStep,
    // quantised code
    output logic [3:0] code
);

    // ----------------------------------------------------------------
    // threshold ladder; saturates at fifteen steps
    // ----------------------------------------------------------------
    logic [19:0] step;

    always_comb begin
        step = fineStep ? {4'h0, ASO_STEP_FINE} : {4'h0, ASO_STEP_COARSE}; // R5
        code = 4'h0;
        for (int k = 1; k < 16; k++) begin
            if ({4'h0, load} >= 20'(k) * step) begin
                code = 4'(k); // R16
            end
        end
    end

endmodule

// ---- aso_status_out.sv ----
`timescale 1ns/1ns
// Summary of operation
// [R1] miss-press flag rises when a press ends without touching the work
// [R2] ready flag high once the controller reports ready; the code keeps it low while the critical fault is latched
// [R3] command current ratio shown as a four-bit code
// [R4] code driven only with all four bits assigned and four or eight points
// [R5] load step is 6.25 % on the fine variant, 18.75 % otherwise
// [R6] pressing flag high during the whole press
// [R7] homing flag high during the whole home return
// [R8] critical fault output goes low and stays low until power cycle
// [R9] motion end set on position, press or miss end; cleared on start
// [R10] overload warning on above threshold, off once below it
// [R11] minor fault output goes low on a light alarm
// [R12] critical, overload and minor outputs are active low
// [R13] drive mode switchable both ways on the capable variant
// [R14] operator picks encoder voltage level to suit cable length
// [R15] alarm output goes low when any alarm is present
// [R16] code bits weigh one, two, four and eight, unsigned
module aso_status_out
    import aso_pkg::*;
#(
    parameter bit DRIVE_SWITCH_EN = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // motion and alarm pins
    input wire aso_pins_type pins,
    // same-clock estimates
    input wire logic [15:0] loadCurrent,
    input wire logic [15:0] motorTemp,
    // status outputs and interrupt
    output aso_flags_type flags,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        aso_pins_type prev;
        logic [15:0] ctrl;
        logic [15:0] thresh;
        logic [ASO_IRQ_W-1:0] irqStat;
        logic [ASO_IRQ_W-1:0] irqMask;
        logic [31:0] rdata;
        aso_flags_type flags;
        logic irq;
    } aso_state_type;

    aso_state_type st;
    aso_state_type next_st;

    logic [ASO_PINS_W-1:0] syncVec;
    aso_pins_type pinS;
    logic [3:0] quantCode;
    logic opStartEdge;
    logic pressEndEdge;
    logic posDoneEdge;
    logic missEvent;
    logic mendEvent;
    logic rateGate;
    logic [ASO_IRQ_W-1:0] events;

    // ----------------------------------------------------------------
    // pin synchroniser and load quantiser
    // ----------------------------------------------------------------
    aso_sync #(
        .WIDTH(ASO_PINS_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .din(pins),
        .dout(syncVec)
    );

    assign pinS = aso_pins_type'(syncVec);

    aso_rate_quant u_quant (
        .load(loadCurrent),
        .fineStep(st.ctrl[ASO_CTRL_VARIANT]),
        .code(quantCode)
    );

    // ----------------------------------------------------------------
    // edges, taken after the second synchroniser stage
    // ----------------------------------------------------------------
    assign opStartEdge = pinS.opStart & ~st.prev.opStart;
    assign pressEndEdge = pinS.pressEnd & ~st.prev.pressEnd;
    assign posDoneEdge = pinS.posDone & ~st.prev.posDone;
    assign missEvent = pressEndEdge & ~pinS.pressContact; // R1
    assign mendEvent = posDoneEdge | pressEndEdge; // R9
    assign rateGate = (st.ctrl[ASO_CTRL_ASSIGN_LSB +: 4] == ASO_ASSIGN_ALL)
        && ((st.ctrl[ASO_CTRL_POINTS_LSB +: 2] == ASO_POINTS_FOUR)
        || (st.ctrl[ASO_CTRL_POINTS_LSB +: 2] == ASO_POINTS_EIGHT)); // R4

    // ----------------------------------------------------------------
    // interrupt events: new arrivals of the miss, motion end, critical, minor, overload and ready flags
    // ----------------------------------------------------------------
    always_comb begin
        events = '0;
        events[ASO_IRQ_MISS] = missEvent;
        events[ASO_IRQ_MOTION_END_FLAG] = mendEvent;
        events[ASO_IRQ_CRIT] = pinS.critAlarm & st.flags.critical_fault_n;
        events[ASO_IRQ_MINOR] = pinS.lightAlarm & st.flags.minor_fault_n;
        events[ASO_IRQ_OVL] = (motorTemp > st.thresh) & st.flags.overload_warning_n;
        events[ASO_IRQ_READY] = pinS.readyIn & ~st.flags.controller_ready_flag
            & st.flags.critical_fault_n;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.prev = pinS;
        next_st.rdata = 32'h0000_0000;

        // register writes
        if (regWr) begin
            case (regAddr)
                ASO_ADDR_CTRL: begin
                    next_st.ctrl = regWdata[15:0];
                end
                ASO_ADDR_THRESH: begin
                    next_st.thresh = regWdata[15:0];
                end
                ASO_ADDR_IRQ_MASK: begin
                    next_st.irqMask = regWdata[ASO_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // register reads; data stand in the following cycle only
        if (regRd) begin
            case (regAddr)
                ASO_ADDR_CTRL: begin
                    next_st.rdata = {16'h0000, st.ctrl};
                end
                ASO_ADDR_THRESH: begin
                    next_st.rdata = {16'h0000, st.thresh};
                end
                ASO_ADDR_STATUS: begin
                    next_st.rdata = {16'h0000, st.flags};
                end
                ASO_ADDR_IRQ_STAT: begin
                    next_st.rdata = {26'h0000000, st.irqStat};
                end
                ASO_ADDR_IRQ_MASK: begin
                    next_st.rdata = {26'h0000000, st.irqMask};
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end

        // read clears; an event in the same cycle still lands
        if (regRd && (regAddr == ASO_ADDR_IRQ_STAT)) begin
            next_st.irqStat = events;
        end else begin
            next_st.irqStat = st.irqStat | events;
        end

        // miss press and motion end: a finish beats a start in one cycle
        if (opStartEdge) begin
            next_st.flags.miss_press_flag = 1'b0;
            next_st.flags.motion_end_flag = 1'b0; // R9
        end
        if (missEvent) begin
            next_st.flags.miss_press_flag = 1'b1; // R1
        end
        if (mendEvent) begin
            next_st.flags.motion_end_flag = 1'b1; // R9
        end

        // critical fault latches until reset, the only stand-in for power off
        if (pinS.critAlarm) begin
            next_st.flags.critical_fault_n = 1'b0; // R8 R12
        end
        next_st.flags.controller_ready_flag = pinS.readyIn
            & next_st.flags.critical_fault_n; // R2
        next_st.flags.minor_fault_n = ~pinS.lightAlarm; // R11 R12
        next_st.flags.alarm_flag_n = next_st.flags.critical_fault_n
            & ~pinS.lightAlarm; // R15

        // overload: equal to threshold keeps the present level
        if (motorTemp > st.thresh) begin
            next_st.flags.overload_warning_n = 1'b0; // R10 R12
        end else if (motorTemp < st.thresh) begin
            next_st.flags.overload_warning_n = 1'b1; // R10
        end

        next_st.flags.pressing = pinS.pressActive; // R6
        next_st.flags.homing_in_progress = pinS.homeActive; // R7
        next_st.flags.currentRate = rateGate ? quantCode : 4'h0; // R3 R4
        next_st.flags.drivePulseMode = DRIVE_SWITCH_EN
            & st.ctrl[ASO_CTRL_DRIVE]; // R13
        // level chosen by the operator to suit the cable
        next_st.flags.encVoltLevel = st.ctrl[ASO_CTRL_ENCV_LSB +: 2]; // R14

        next_st.irq = |(next_st.irqStat & next_st.irqMask);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.prev <= '0;
            st.ctrl <= ASO_CTRL_RESET;
            st.thresh <= ASO_THRESH_RESET;
            st.irqStat <= '0;
            st.irqMask <= '0;
            st.rdata <= 32'h0000_0000;
            st.flags <= ASO_FLAGS_RESET;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
    assign irq = st.irq;
    assign regRdata = st.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence press_miss_s;
        pressEndEdge && !pinS.pressContact && !opStartEdge;
    endsequence

    sequence start_only_s;
        opStartEdge && !mendEvent;
    endsequence

    chk_miss_press_set: assert property (press_miss_s |=> flags.miss_press_flag) // R1
        else $error("miss press flag not set after press without contact");

    chk_ready_follows: assert property (
        (pinS.readyIn && !pinS.critAlarm && flags.critical_fault_n)
        |=> flags.controller_ready_flag) // R2
        else $error("ready flag missing");

    chk_rate_code: assert property (rateGate |=> flags.currentRate == $past(quantCode)) // R3
        else $error("current rate code mismatch");

    chk_rate_gated: assert property (!rateGate |=> flags.currentRate == 4'h0) // R4
        else $error("current rate driven without full assignment");

    chk_pressing_level: assert property (
        pinS.pressActive [*2] |-> flags.pressing ##1 flags.pressing) // R6
        else $error("pressing flag dropped during press");

    chk_homing_level: assert property (
        pinS.homeActive == !flags.homing_in_progress |=> flags.homing_in_progress
        == $past(pinS.homeActive)) // R7
        else $error("homing flag not following");

    chk_critical_sticky: assert property (
        !flags.critical_fault_n |=> !flags.critical_fault_n [*3]) // R8
        else $error("critical fault released without reset");

    chk_motion_end_flag_clear: assert property (start_only_s |=> !flags.motion_end_flag) // R9
        else $error("motion end not cleared at start");

    chk_motion_end_flag_set: assert property (mendEvent |=> flags.motion_end_flag) // R9
        else $error("motion end not set on completion");

    chk_overload_warn: assert property (
        (motorTemp > st.thresh) |=> !flags.overload_warning_n) // R10 R12
        else $error("overload warning not driven low");

    chk_overload_clear: assert property (
        (motorTemp < st.thresh) |=> flags.overload_warning_n) // R10
        else $error("overload warning stuck");

    chk_minor_fault: assert property (pinS.lightAlarm |=> !flags.minor_fault_n) // R11 R12
        else $error("minor fault not driven low");

    chk_alarm_any: assert property (
        (pinS.critAlarm || pinS.lightAlarm) |=> !flags.alarm_flag_n) // R15
        else $error("alarm output high during alarm");

    chk_drive_mode: assert property (
        ##1 flags.drivePulseMode == (DRIVE_SWITCH_EN && $past(st.ctrl[ASO_CTRL_DRIVE]))) // R13
        else $error("drive mode does not follow control");

    chk_irq_level: assert property (
        irq == ((st.irqStat & st.irqMask) != '0))
        else $error("interrupt level disagrees with status and mask");

    sequence stat_read_s;
        regRd && (regAddr == ASO_ADDR_IRQ_STAT);
    endsequence

    sequence flags_read_s;
        regRd && (regAddr == ASO_ADDR_STATUS);
    endsequence

    chk_stat_cleared: assert property (stat_read_s |=> st.irqStat == $past(events))
        else $error("status read did not clear to same-cycle events");

    chk_stat_sticky: assert property (
        !(regRd && (regAddr == ASO_ADDR_IRQ_STAT))
        |=> (st.irqStat & $past(st.irqStat)) == $past(st.irqStat))
        else $error("status bit lost without a read");

    chk_status_read: assert property ( // R12
        flags_read_s |=> regRdata == {16'h0000, $past(flags)})
        else $error("status read data mismatch");

    chk_rdata_idle: assert property (!regRd |=> regRdata == 32'h0000_0000)
        else $error("read data not zero outside a read");

    chk_miss_clear: assert property ( // R1
        (opStartEdge && !missEvent) |=> !flags.miss_press_flag)
        else $error("miss press flag not cleared at start");

    chk_crit_set: assert property (pinS.critAlarm |=> !flags.critical_fault_n) // R8 R12
        else $error("critical fault output not driven low");

    chk_ready_blocked: assert property ( // R2
        !flags.critical_fault_n |-> !flags.controller_ready_flag)
        else $error("ready flag high during critical fault");

    chk_overload_hold: assert property ( // R10
        (motorTemp == st.thresh) |=> $stable(flags.overload_warning_n))
        else $error("overload warning moved at equal threshold");

    chk_encoder_level: assert property ( // R14
        ##1 flags.encVoltLevel == $past(st.ctrl[ASO_CTRL_ENCV_LSB +: 2]))
        else $error("encoder level does not follow control");

    chk_ctrl_write: assert property ( // R13
        (regWr && (regAddr == ASO_ADDR_CTRL)) |=> st.ctrl == $past(regWdata[15:0]))
        else $error("control write did not land");

endmodule

// ---- aso_sync.sv ----
`timescale 1ns/1ns
module aso_sync
    import aso_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and synchronised copy
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ----------------------------------------------------------------
    // two stages; the first stage feeds only the second
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import aso_pkg::*;
    typedef struct {
        string what;
        logic [31:0] value;
    } aso_note_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    aso_pins_type pinsCmd = 9'h000;
    aso_pins_type pins;
    logic slow = 1'b0;
    logic cableLong = 1'b0;
    logic [1:0] encLevel;
    logic [15:0] loadCurrent = 16'h0000;
    logic [15:0] motorTemp = 16'h0000;
    aso_flags_type flags;
    aso_flags_type ef;
    logic irq;
    logic rdSeen = 1'b0;
    aso_note_type noteQ[$];
    int n_errors = 0;
    int compares = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    aso_status_out #(.DRIVE_SWITCH_EN(1'b1)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pins(pins),
        .loadCurrent(loadCurrent), .motorTemp(motorTemp), .flags(flags), .irq(irq));
    aso_host_model host (.clk(clk), .pinsCmd(pinsCmd), .slow(slow), .cableLong(cableLong),
        .pins(pins), .encLevel(encLevel));

    // ----------------------------------------------------------------
    // compare and bus tasks
    // ----------------------------------------------------------------
    task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_bit(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string what);
        aso_note_type n;
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        n.what = what;
        n.value = e;
        noteQ.push_back(n);
        @(posedge clk);
        regRd <= 1'b0;
    endtask

    task automatic status();
        reg_rd(ASO_ADDR_STATUS, {16'h0000, ef}, "status");
    endtask

    task automatic events(input logic [5:0] e);
        reg_rd(ASO_ADDR_IRQ_STAT, {26'h0, e}, "irq status");
    endtask

    task automatic pin_step(input aso_pins_type p);
        pinsCmd <= p;
        repeat (6) @(posedge clk);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1 check_bit("irq", e, irq);
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && compares > 0 && noteQ.size() == 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        aso_note_type n;
        if (rdSeen) begin
            n = noteQ.pop_front();
            check_word(n.what, n.value, regRdata);
            if (n.what == "status") begin
                check_word("flags port", n.value, {16'h0000, flags});
            end
        end
        rdSeen <= regRd;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        int code;
        logic [1:0] pts;
        logic [15:0] ctrl;
        logic [15:0] ld;
        logic [15:0] st;
        logic [15:0] t;
        void'($urandom(32'h28413028));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        ef = ASO_FLAGS_RESET;
        status();
        reg_rd(ASO_ADDR_CTRL, {16'h0000, ASO_CTRL_RESET}, "ctrl");
        reg_rd(ASO_ADDR_THRESH, {16'h0000, ASO_THRESH_RESET}, "thresh");
        reg_rd(8'h14, 32'h0, "unmapped");
        reg_wr(ASO_ADDR_STATUS, 32'h0000FFFF);
        status();
        reg_wr(ASO_ADDR_IRQ_MASK, 32'h0000003F);
        pin_step(9'h001);
        ef.controller_ready_flag = 1'b1;
        status();
        irq_is(1'b1);
        events(6'h20);
        irq_is(1'b0);
        pin_step(9'h031);
        ef.pressing = 1'b1;
        ef.homing_in_progress = 1'b1;
        status();
        pin_step(9'h091);
        ef.pressing = 1'b0;
        ef.miss_press_flag = 1'b1;
        ef.motion_end_flag = 1'b1;
        status();
        events(6'h03);
        pin_step(9'h111);
        ef.miss_press_flag = 1'b0;
        ef.motion_end_flag = 1'b0;
        status();
        pin_step(9'h009);
        ef.homing_in_progress = 1'b0;
        ef.motion_end_flag = 1'b1;
        status();
        pin_step(9'h101);
        ef.motion_end_flag = 1'b0;
        status();
        pin_step(9'h0C1);
        ef.motion_end_flag = 1'b1;
        status();
        events(6'h02);
        // code only for all four bits assigned and four or eight points
        for (int i = 0; i < 12; i++) begin
            pts = (i % 4 == 1) ? ASO_POINTS_EIGHT : ((i % 4 == 2) ? 2'h0 : ASO_POINTS_FOUR);
            ctrl = 16'h0000;
            ctrl[ASO_CTRL_VARIANT] = (i % 2 == 0);
            ctrl[ASO_CTRL_POINTS_LSB +: 2] = pts;
            ctrl[ASO_CTRL_ASSIGN_LSB +: 4] = (i % 4 == 3) ? 4'h7 : ASO_ASSIGN_ALL;
            ld = 16'($urandom % 1300);
            reg_wr(ASO_ADDR_CTRL, {16'h0000, ctrl});
            loadCurrent <= ld;
            repeat (3) @(posedge clk);
            st = (i % 2 == 0) ? ASO_STEP_FINE : ASO_STEP_COARSE;
            code = ld / st;
            code = (code > 15) ? 15 : code;
            ef.currentRate = (i % 4 < 2) ? 4'(code) : 4'h0;
            status();
        end
        cableLong <= 1'b1;
        @(posedge clk);
        ctrl = 16'h0000;
        ctrl[ASO_CTRL_DRIVE] = 1'b1;
        ctrl[ASO_CTRL_ENCV_LSB +: 2] = encLevel;
        reg_wr(ASO_ADDR_CTRL, {16'h0000, ctrl});
        ef = '{default: 1'b0, critical_fault_n: 1'b1, overload_warning_n: 1'b1,
            minor_fault_n: 1'b1, alarm_flag_n: 1'b1, controller_ready_flag: 1'b1,
            motion_end_flag: 1'b1, drivePulseMode: 1'b1, encVoltLevel: encLevel};
        status();
        reg_wr(ASO_ADDR_CTRL, 32'h00000000);
        ef.drivePulseMode = 1'b0;
        ef.encVoltLevel = 2'h0;
        status();
        t = 16'($urandom % 60000) + 16'h0002;
        reg_wr(ASO_ADDR_THRESH, {16'h0000, t});
        motorTemp <= t + 16'h0001;
        repeat (3) @(posedge clk);
        ef.overload_warning_n = 1'b0;
        status();
        events(6'h10);
        motorTemp <= t - 16'h0001;
        repeat (3) @(posedge clk);
        ef.overload_warning_n = 1'b1;
        status();
        // light alarm masked out, brought in by a slow far side
        reg_wr(ASO_ADDR_IRQ_MASK, 32'h00000037);
        slow <= 1'b1;
        pin_step(9'h003);
        ef.minor_fault_n = 1'b0;
        ef.alarm_flag_n = 1'b0;
        status();
        irq_is(1'b0);
        events(6'h08);
        pin_step(9'h001);
        slow <= 1'b0;
        ef.minor_fault_n = 1'b1;
        ef.alarm_flag_n = 1'b1;
        status();
        pin_step(9'h005);
        pin_step(9'h001);
        ef.critical_fault_n = 1'b0;
        ef.alarm_flag_n = 1'b0;
        ef.controller_ready_flag = 1'b0;
        status();
        irq_is(1'b1);
        // only a reset, standing for a power cycle, clears the fault
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        ef = ASO_FLAGS_RESET;
        ef.controller_ready_flag = 1'b1;
        status();
        // let the last read reach the watcher before the verdict
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule
